/* File: rjp_pin_ctrl.sv */
// Purpose: reset pin, ramp clock and port 0 bits 0..5 pin control
// Assumes: all inputs synchronous to clock except reset pin level
// Notes:   tap and spi state machines live outside
//          reset pad is open drain; only its enable ever moves
//          cpu release costs three edges after the pad reads high
//          config writes are ignored while the cpu is held in reset
//          pad levels reach gpio, irq, tap and spi one edge late
//          tdo is the only special function that drives its pad
//          tms reads high whenever the tap cannot see its pad
//          pads are taken as synchronous, so one stage is enough there
//          the reset pad may move at any time, so it gets two stages
`timescale 1ns/100ps
`include "rjp_params.svh"
module rjp_pin_ctrl (
  input  wire logic                     clock,
  input  wire logic                     rst_n,
  // reset pin, open drain
  input  wire logic                     rst_pin_in,
  output logic                          rst_pin_out,
  output logic                          rst_pin_oe,
  input  wire logic                     int_rst_req,
  output logic                          cpu_rst_n,
  // ramp clock
  input  wire logic [`RJP_DIV_W-1:0]    ramp_div_sel,
  output logic                          ramp_sync_clock,
  // system control register bits
  input  wire logic                     tap_en,
  input  wire logic                     cfg_wr,
  input  wire logic [`RJP_NUM_PINS-1:0] cfg_sf,
  input  wire logic [`RJP_NUM_PINS-1:0] cfg_pullup,
  output logic [`RJP_NUM_PINS-1:0]      sf_sel,
  // gpio side
  input  wire logic [`RJP_NUM_PINS-1:0] gpio_out,
  input  wire logic [`RJP_NUM_PINS-1:0] gpio_dir,
  output logic [`RJP_NUM_PINS-1:0]      gpio_in,
  output logic [`RJP_NUM_PINS-1:0]      pin_irq,
  // pads
  input  wire logic [`RJP_NUM_PINS-1:0] port0_in,
  output logic [`RJP_NUM_PINS-1:0]      port0_out,
  output logic [`RJP_NUM_PINS-1:0]      port0_oe,
  output logic [`RJP_NUM_PINS-1:0]      port0_pullup,
  // test access port
  output logic                          tap_tck,
  output logic                          tap_tdi,
  output logic                          tap_tms,
  input  wire logic                     tap_tdo,
  input  wire logic                     tap_shift_ir,
  input  wire logic                     tap_shift_dr,
  // spi slave
  output logic                          spi_ssel_n,
  output logic                          spi_sclk
);
  // reset sequencer
  rjp_pkg::rjp_rst_state_t st_r;
  rjp_pkg::rjp_rst_state_t st_nxt;
  logic [`RJP_SYNC_STAGES-1:0] rst_sync_r;

  // pin configuration and pad sampling
  logic [`RJP_NUM_PINS-1:0]    sf_r;
  logic [`RJP_NUM_PINS-1:0]    pullup_r;
  logic [`RJP_NUM_PINS-1:0]    in_r;

  // special-function routing
  logic [`RJP_NUM_PINS-1:0]    tap_pin;
  logic [`RJP_NUM_PINS-1:0]    spi_pin;
  logic [`RJP_NUM_PINS-1:0]    sf_act;
  logic [`RJP_NUM_PINS-1:0]    sf_oe;
  logic [`RJP_NUM_PINS-1:0]    sf_out;

  // two-stage sync of the reset pin; stage 0 feeds only stage 1
  // nothing else may read stage 0, it can still be settling
  // from a metastable sample of an asynchronous pad edge
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n)
      rst_sync_r <= '0;
    else
      rst_sync_r <= {rst_sync_r[0], rst_pin_in};
  end

  wire pin_high = rst_sync_r[`RJP_SYNC_STAGES-1];

  // hold until pin high; drive pin low while an internal source is active,
  // then wait for the pin to come back high before releasing
  // waiting for the pad after an internal reset costs a few cycles
  // but guarantees that external parts saw the pulse end too
  // an internal source always wins over the pad level
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      rjp_pkg::RJP_ST_HOLD: begin
        if (int_rst_req)
          st_nxt = rjp_pkg::RJP_ST_DRIVE;
        else if (pin_high)
          st_nxt = rjp_pkg::RJP_ST_RUN;
      end
      rjp_pkg::RJP_ST_DRIVE: begin
        if (!int_rst_req)
          st_nxt = rjp_pkg::RJP_ST_HOLD;
      end
      rjp_pkg::RJP_ST_RUN: begin
        if (int_rst_req)
          st_nxt = rjp_pkg::RJP_ST_DRIVE;
        else if (!pin_high)
          st_nxt = rjp_pkg::RJP_ST_HOLD;
      end
      default: st_nxt = rjp_pkg::RJP_ST_HOLD;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n)
      st_r <= rjp_pkg::RJP_ST_HOLD;
    else
      st_r <= st_nxt;
  end

  wire st_is_run   = (st_r == rjp_pkg::RJP_ST_RUN);
  wire st_is_drive = (st_r == rjp_pkg::RJP_ST_DRIVE);

  assign cpu_rst_n   = st_is_run;
  // data stays low; the enable alone pulls the pad
  assign rst_pin_out = 1'b0;
  assign rst_pin_oe  = st_is_drive;

  // ramp sync clock; a ratio change acts on the half period in progress,
  // which never ends sooner than the new ratio's half period
  rjp_ramp_div u_div (
    .clock           (clock),
    .rst_n           (rst_n),
    .div_sel         (ramp_div_sel),
    .ramp_sync_clock (ramp_sync_clock)
  );

  // pin config; internal reset also restores defaults
  wire cfg_revert = ~st_is_run;
  wire cfg_load   = cfg_wr & st_is_run;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n)
      sf_r <= `RJP_SF_RST;
    else if (cfg_revert)
      sf_r <= `RJP_SF_RST;
    else if (cfg_load)
      sf_r <= cfg_sf;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n)
      pullup_r <= `RJP_PULLUP_RST;
    else if (cfg_revert)
      pullup_r <= `RJP_PULLUP_RST;
    else if (cfg_load)
      pullup_r <= cfg_pullup;
  end

  // one stage: pads are taken as synchronous to the clock
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n)
      in_r <= '0;
    else
      in_r <= port0_in;
  end

  // tap pins freed together when the tap is disabled
  assign tap_pin = {2'b00, {4{tap_en}}};
  // spi claims bits 4 and 5 whatever the tap bit says
  assign spi_pin = {2'b11, 4'h0};
  assign sf_act  = sf_r & (tap_pin | spi_pin);

  // tdo is the only special function that drives its pad
  wire tdo_drive = tap_shift_ir | tap_shift_dr;
  assign sf_oe   = {2'b00, tdo_drive, 3'b000};
  assign sf_out  = {2'b00, tap_tdo, 3'b000};

  genvar i;
  generate
    for (i = 0; i < `RJP_NUM_PINS; i = i + 1) begin : g_pin
      // special function disconnects the gpio path entirely
      wire sf_on  = sf_act[i];
      wire sf_drv = sf_on & sf_oe[i];
      wire gp_lvl = sf_on ? 1'b0 : in_r[i];
      assign port0_oe[i]     = sf_on ? sf_oe[i] : gpio_dir[i];
      assign port0_out[i]    = sf_on ? sf_out[i] : gpio_out[i];
      // pull-up off only while tdo actively drives the pad
      assign port0_pullup[i] = pullup_r[i] & ~sf_drv;
      assign gpio_in[i]      = gp_lvl;
      assign pin_irq[i]      = gp_lvl;
    end
  endgenerate

  // per-function select and registered pad level
  wire sel_tck  = sf_act[`RJP_BIT_TCK];
  wire sel_tdi  = sf_act[`RJP_BIT_TDI];
  wire sel_tms  = sf_act[`RJP_BIT_TMS];
  wire sel_ssel = sf_act[`RJP_BIT_SSEL];
  wire sel_sclk = sf_act[`RJP_BIT_SCLK];
  wire lvl_tck  = in_r[`RJP_BIT_TCK];
  wire lvl_tdi  = in_r[`RJP_BIT_TDI];
  wire lvl_tms  = in_r[`RJP_BIT_TMS];
  wire lvl_ssel = in_r[`RJP_BIT_SSEL];
  wire lvl_sclk = in_r[`RJP_BIT_SCLK];

  assign sf_sel     = sf_act;
  assign tap_tck    = sel_tck & lvl_tck;
  assign tap_tdi    = sel_tdi & lvl_tdi;
  // mode forced high keeps the tap idle when off or not selected
  assign tap_tms    = sel_tms ? lvl_tms : 1'b1;
  // deselected slave select idles inactive
  assign spi_ssel_n = sel_ssel ? lvl_ssel : 1'b1;
  assign spi_sclk   = sel_sclk & lvl_sclk;
endmodule

/* File: rjp_params.svh */
// Purpose: constants for the reset, ramp clock and port 0 pin control block
// Assumes: 50 MHz system clock
// Notes:   definitions only
`ifndef RJP_PARAMS_SVH
`define RJP_PARAMS_SVH

`define RJP_NUM_PINS       6
`define RJP_DIV_W          4
`define RJP_SYNC_STAGES    2
`define RJP_BIT_TCK        0
`define RJP_BIT_TDI        1
`define RJP_BIT_TMS        2
`define RJP_BIT_TDO        3
`define RJP_BIT_SSEL       4
`define RJP_BIT_SCLK       5
`define RJP_PULLUP_RST     6'h3f
`define RJP_SF_RST         6'h00
`define RJP_TAP_EN_RST     1'b1
`define RJP_DIV_SEL_RST    4'h0

`endif

/* File: rjp_pkg.sv */
// Purpose: types for the pin control block
// Assumes: nothing
// Notes:   reset sequencer states
package rjp_pkg;
  typedef enum logic [2:0] {
    RJP_ST_HOLD = 3'b001,
    RJP_ST_DRIVE = 3'b010,
    RJP_ST_RUN = 3'b100
  } rjp_rst_state_t;
endpackage

/* File: rjp_ramp_div.sv */
// Purpose: ramp sync clock divider
// Assumes: divide ratio = 2*(sel+1)
// Notes:   output from a flip-flop, glitch free
`timescale 1ns/100ps
`include "rjp_params.svh"
module rjp_ramp_div (
  input  wire logic                  clock,
  input  wire logic                  rst_n,
  input  wire logic [`RJP_DIV_W-1:0] div_sel,
  output logic                       ramp_sync_clock
);
  logic [`RJP_DIV_W-1:0] cnt_r;
  logic                  clk_r;
  wire                   wrap = (cnt_r >= div_sel);

  // half period of sel+1 cycles; ratio change also acts on the half period in progress
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      clk_r <= 1'b0;
    end else if (wrap) begin
      cnt_r <= '0;
      clk_r <= ~clk_r;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  assign ramp_sync_clock = clk_r;
endmodule

/* File: rjp_pin_ctrl_asserts.sv */
// Purpose: port-level checks of the pin control block
// Assumes: one clock domain, async active-low reset
// Notes:   bound into the design below
`timescale 1ns/100ps
module rjp_pin_ctrl_asserts (
  input wire logic       clock, rst_n, rst_pin_in, rst_pin_oe, int_rst_req,
  input wire logic       cpu_rst_n, tap_en, tap_tms, tap_tck, tap_tdo,
  input wire logic       tap_shift_ir, tap_shift_dr, spi_ssel_n, spi_sclk,
  input wire logic [5:0] sf_sel, port0_in, port0_oe, port0_out, port0_pullup
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_pad_lo; !rst_pin_in; endsequence
  sequence s_pad_rise; s_pad_lo ##1 rst_pin_in; endsequence
  property p_hold; s_pad_lo |-> ##3 !cpu_rst_n; endproperty
  a_hold: assert property (p_hold) else $error("cpu ran, pad low");
  property p_sync; s_pad_rise |-> ##1 !cpu_rst_n ##1 !cpu_rst_n; endproperty
  a_sync: assert property (p_sync) else $error("release too early");
  property p_drive; int_rst_req |=> rst_pin_oe; endproperty
  a_drive: assert property (p_drive) else $error("pad not pulled");
  property p_dflt;
    !cpu_rst_n && !$past(cpu_rst_n) |-> port0_pullup == 6'h3f && !sf_sel;
  endproperty
  a_dflt: assert property (p_dflt) else $error("bad pin defaults");
  property p_tdo; sf_sel[3] |-> port0_oe[3] == (tap_shift_ir | tap_shift_dr)
    && port0_out[3] == tap_tdo; endproperty
  a_tdo: assert property (p_tdo) else $error("tdo drive wrong");
  property p_free; !tap_en |-> sf_sel[3:0] == 4'h0; endproperty
  a_free: assert property (p_free) else $error("tap pins held");
  property p_tms; !tap_en && !$past(tap_en) |-> tap_tms; endproperty
  a_tms: assert property (p_tms) else $error("mode not high");
  property p_tck; sf_sel[0] && $past(sf_sel[0]) |->
    tap_tck == $past(port0_in[0]) && !port0_oe[0]; endproperty
  a_tck: assert property (p_tck) else $error("tck path wrong");
  property p_ssel; sf_sel[4] && $past(sf_sel[4]) |->
    spi_ssel_n == $past(port0_in[4]); endproperty
  a_ssel: assert property (p_ssel) else $error("ssel path wrong");
  property p_sclk; sf_sel[5] && $past(sf_sel[5]) |->
    spi_sclk == $past(port0_in[5]); endproperty
  a_sclk: assert property (p_sclk) else $error("sclk path wrong");
endmodule
bind rjp_pin_ctrl rjp_pin_ctrl_asserts i_rjp_pin_ctrl_asserts (.*);

/* File: rjp_pads_model.sv */
// Purpose: pads, external reset source, debugger and spi peer drive
// Assumes: reset pad has a pull-up, open drain on both sides
// Notes:   port pads without pull-up or driver toggle
`timescale 1ns/100ps
module rjp_pads_model (
  input  wire logic       clock,
  input  wire logic       rst_pin_oe,
  input  wire logic       ext_rst_low,
  input  wire logic [5:0] port0_out,
  input  wire logic [5:0] port0_oe,
  input  wire logic [5:0] port0_pullup,
  input  wire logic [5:0] ext_en,
  input  wire logic [5:0] ext_v,
  output logic            rst_pin_in,
  output logic [5:0]      port0_in
);
  logic flip_r = 1'b0;
  always @(posedge clock) flip_r <= ~flip_r;
  assign rst_pin_in = ~(rst_pin_oe | ext_rst_low);
  // floating pad must not keep a stale level
  assign port0_in = (port0_oe & port0_out) | (~port0_oe & ext_en & ext_v)
    | (~port0_oe & ~ext_en & (port0_pullup | {6{flip_r}}));
endmodule

/* File: rjp_pin_ctrl_test.sv */
// Purpose: directed test of the pin control block
// Assumes: 50 MHz clock, inputs driven 1 ns after the edge
// Notes:   pads come from rjp_pads_model
`timescale 1ns/100ps
module rjp_pin_ctrl_test;
  logic clock = 0, rst_n = 0, int_rst_req = 0, cfg_wr = 0, tap_en = 1;
  logic tap_tdo = 0, tap_shift_ir = 0, tap_shift_dr = 0, ext_rst_low = 0;
  logic [3:0] ramp_div_sel = 4'h0;
  logic [5:0] cfg_sf = 0, cfg_pullup = 0, gpio_out = 0, gpio_dir = 0;
  logic [5:0] ext_en = 0, ext_v = 0, sf_sel, gpio_in, pin_irq, port0_in;
  logic [5:0] port0_out, port0_oe, port0_pullup;
  logic rst_pin_in, rst_pin_oe, cpu_rst_n, ramp_sync_clock, tap_tck;
  logic tap_tdi, tap_tms, spi_ssel_n, spi_sclk;
  int err_total = 0, total_checks = 0, cyc = 0;
  rjp_pin_ctrl i_rjp_pin_ctrl (.*, .rst_pin_out());
  rjp_pads_model i_rjp_pads_model (.*);
  always #10 clock = ~clock;
  task tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc++;
    // whole run is about 160 cycles
    if (cyc == 5000) begin err_total++; tally_and_finish; end
  end
  task step(input int n); repeat (n) @(posedge clock); #1; endtask
  task chk(input logic [7:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task cfg(input logic [5:0] sf, pu);
    cfg_wr = 1; cfg_sf = sf; cfg_pullup = pu; step(1); cfg_wr = 0; step(1);
  endtask
  task wait_cpu; while (cpu_rst_n !== 1'b1) step(1); step(2); endtask
  task ramp_len(input logic [3:0] sel);
    int n;
    ramp_div_sel = sel; step(40); n = 0;
    while (ramp_sync_clock !== 1'b0) step(1);
    while (ramp_sync_clock !== 1'b1) step(1);
    while (ramp_sync_clock === 1'b1) begin step(1); n++; end
    chk(n[7:0], {4'h0, sel} + 8'h1);
  endtask
  initial begin
    step(6); rst_n = 1; wait_cpu;
    chk({sf_sel, 2'h0}, 8'h00);
    chk(port0_pullup, 8'h3f);
    chk(gpio_in & pin_irq, 8'h3f);
    ext_rst_low = 1; step(4); chk(cpu_rst_n, 8'h0);
    ext_rst_low = 0; step(2); chk(cpu_rst_n, 8'h0);
    step(1); chk(cpu_rst_n, 8'h1);
    $display("test reset pin done");
    cfg(6'h30, 6'h00); int_rst_req = 1; step(1);
    chk(rst_pin_oe, 8'h1);
    step(3); chk(cpu_rst_n, 8'h0);
    int_rst_req = 0; wait_cpu;
    chk({2'h0, sf_sel}, 8'h00);
    chk({2'h0, port0_pullup}, 8'h3f);
    $display("test internal reset done");
    cfg(6'h0f, 6'h00); chk(sf_sel, 8'h0f);
    ext_en = 6'h07;
    for (int v = 0; v < 8; v++) begin
      ext_v = v[5:0]; step(2);
      chk({tap_tms, tap_tdi, tap_tck}, v[7:0]);
      chk({gpio_in[3:0], pin_irq[3:0]}, 8'h00);
    end
    tap_tdo = 1;
    for (int s = 0; s < 4; s++) begin
      {tap_shift_ir, tap_shift_dr} = s[1:0]; step(1);
      chk({port0_oe[3], port0_out[3]}, {6'h0, s != 0, 1'b1});
    end
    {tap_shift_ir, tap_shift_dr} = 2'h0; tap_en = 0; ext_v = 6'h02; step(2);
    chk(sf_sel, 8'h00);
    chk(tap_tms, 8'h1);
    chk(gpio_in[2:0], 8'h2);
    tap_en = 1; $display("test tap done");
    cfg(6'h30, 6'h00); ext_en = 6'h30; ext_v = 6'h20; step(2);
    chk({spi_sclk, spi_ssel_n, gpio_in[5:4]}, 8'h8);
    ext_v = 6'h10; step(2); chk({spi_sclk, spi_ssel_n}, 8'h1);
    cfg(6'h00, 6'h3f); ext_en = 0; gpio_dir = 6'h30; gpio_out = 6'h10;
    step(2);
    chk({port0_oe[5:4], port0_out[5:4]}, 8'hd);
    chk({spi_ssel_n, gpio_in[5:4]}, 8'h5);
    $display("test spi done");
    ramp_len(4'h0);
    ramp_len(4'h3);
    $display("test ramp done");
    tally_and_finish;
  end
endmodule
